// ---- verilog/rcr_pkg.sv ----
// Shared constants and types for the regulator configuration registers.
package rcr_pkg;
    localparam logic [7:0] RCR_OFS_RAMP = 8'h2B;
    localparam logic [7:0] RCR_OFS_FUNC = 8'h38;
    localparam logic [7:0] RCR_OFS_LDO1 = 8'h39;
    localparam logic [7:0] RCR_OFS_LDO2 = 8'h3A;
    localparam logic [7:0] RCR_RST_RAMP = 8'h28;
    localparam logic [7:0] RCR_RST_FUNC = 8'h06;
    localparam logic [7:0] RCR_RST_LDO = 8'h00;
    localparam logic [7:0] RCR_MSK_RAMP = 8'h0F;
    localparam logic [7:0] RCR_MSK_FUNC = 8'h1F;
    localparam logic [7:0] RCR_MSK_LDO = 8'h1F;
    localparam int RCR_BIT_SSEN = 0;
    localparam int RCR_BIT_SLOW = 1;
    localparam int RCR_BIT_DLY = 2;
    localparam int RCR_BIT_BYP = 4;
    localparam logic [3:0] RCR_RAMP_MAX = 4'hA;
    localparam logic [4:0] RCR_LDO_MAX = 5'h19;
    localparam logic [5:0] RCR_LDO_BASE = 6'h0A;
    localparam int RCR_CLK_NS = 8;
    localparam int RCR_PG_DLY0_US = 50;
    localparam int RCR_PG_DLY1_MS = 50;
    localparam int RCR_PG_DLY2_MS = 100;
    localparam int RCR_PG_DLY3_MS = 200;
    localparam int RCR_PG_CYC0 = (RCR_PG_DLY0_US * 1000 + RCR_CLK_NS - 1) / RCR_CLK_NS;
    localparam int RCR_PG_CYC1 = (RCR_PG_DLY1_MS * 1000000 + RCR_CLK_NS - 1) / RCR_CLK_NS;
    localparam int RCR_PG_CYC2 = (RCR_PG_DLY2_MS * 1000000 + RCR_CLK_NS - 1) / RCR_CLK_NS;
    localparam int RCR_PG_CYC3 = (RCR_PG_DLY3_MS * 1000000 + RCR_CLK_NS - 1) / RCR_CLK_NS;
    localparam int RCR_SS_FAST_KHZ = 10;
    localparam int RCR_SS_SLOW_KHZ = 2;
    localparam int RCR_SS_HALF_FAST = (500000 / RCR_SS_FAST_KHZ) / RCR_CLK_NS;
    localparam int RCR_SS_HALF_SLOW = (500000 / RCR_SS_SLOW_KHZ) / RCR_CLK_NS;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcr_req_t;
    typedef enum logic [2:0] {
        RCR_PG_HOLD = 3'b001,
        RCR_PG_COUNT = 3'b010,
        RCR_PG_GOOD = 3'b100
    } rcr_pg_state_t;
endpackage : rcr_pkg

// ---- verilog/rcr_spread.sv ----
// Triangular spread-spectrum direction generator for the switcher clock.
`timescale 1ns/1ns
module rcr_spread
    import rcr_pkg::*;
#(
    parameter int HALF_FAST = RCR_SS_HALF_FAST,
    parameter int HALF_SLOW = RCR_SS_HALF_SLOW,
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Control.
    input wire logic i_enable,
    input wire logic i_slow,
    // Modulation state.
    output logic o_active,
    output logic o_up
);
    initial begin
        if (HALF_FAST < 1 || HALF_SLOW < 1 || HALF_SLOW >= (1 << CNT_W)) begin
            $error("rcr_spread: bad half period");
        end
    end
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, lim;
    logic up_ff, nxt_up, act_ff, nxt_act;
    always_comb begin
        lim = i_slow ? CNT_W'(HALF_SLOW - 1) : CNT_W'(HALF_FAST - 1);
        nxt_act = i_enable;
        nxt_cnt = '0;
        nxt_up = 1'b1;
        if (i_enable) begin
            // A rate change mid-slope takes effect at once; >= avoids a wrap.
            nxt_cnt = (cnt_ff >= lim) ? '0 : cnt_ff + 1'b1;
            nxt_up = (cnt_ff >= lim) ? ~up_ff : up_ff;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
            up_ff <= 1'b1;
            act_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            up_ff <= nxt_up;
            act_ff <= nxt_act;
        end
    end
    assign o_active = act_ff;
    assign o_up = up_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_ss_turn;
        i_enable && act_ff && cnt_ff < lim |=> $stable(up_ff);
    endproperty
    a_ss_turn: assert property (p_ss_turn) else $error("slope turned early");
endmodule : rcr_spread

// ---- verilog/rcr_pg_delay.sv ----
// Power-good reset delay timer driven by the buck output monitor.
`timescale 1ns/1ns
module rcr_pg_delay
    import rcr_pkg::*;
#(
    parameter int CNT_W = 25,
    parameter int CYC0 = RCR_PG_CYC0,
    parameter int CYC1 = RCR_PG_CYC1,
    parameter int CYC2 = RCR_PG_CYC2,
    parameter int CYC3 = RCR_PG_CYC3
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Monitor and delay choice.
    input wire logic i_ok,
    input wire logic [1:0] i_sel,
    // Active-low reset output.
    output logic o_reset_n
);
    initial begin
        if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 || CYC3 >= (1 << CNT_W)) begin
            $error("rcr_pg_delay: bad delay count");
        end
    end
    rcr_pg_state_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt, lim;
    logic rn_ff, nxt_rn;
    always_comb begin
        unique case (i_sel)
            2'h0: lim = CNT_W'(CYC0 - 1);
            2'h1: lim = CNT_W'(CYC1 - 1);
            2'h2: lim = CNT_W'(CYC2 - 1);
            2'h3: lim = CNT_W'(CYC3 - 1);
        endcase
        nxt_st = st_ff;
        nxt_cnt = '0;
        unique case (st_ff)
            RCR_PG_HOLD: if (i_ok) nxt_st = RCR_PG_COUNT;
            RCR_PG_COUNT: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= lim) nxt_st = RCR_PG_GOOD;
            end
            RCR_PG_GOOD: nxt_st = RCR_PG_GOOD;
            default: nxt_st = RCR_PG_HOLD;
        endcase
        // Any dip of the monitor restarts the whole delay.
        if (!i_ok) begin
            nxt_st = RCR_PG_HOLD;
            nxt_cnt = '0;
        end
        nxt_rn = (nxt_st == RCR_PG_GOOD);
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= RCR_PG_HOLD;
            cnt_ff <= '0;
            rn_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rn_ff <= nxt_rn;
        end
    end
    assign o_reset_n = rn_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_pg_drop;
        !i_ok |=> !rn_ff;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("reset not asserted on drop");
    property p_pg_rel;
        $rose(rn_ff) |-> $past(st_ff) == RCR_PG_COUNT && $past(cnt_ff) >= $past(lim);
    endproperty
    a_pg_rel: assert property (p_pg_rel) else $error("reset released early");
endmodule : rcr_pg_delay

// ---- verilog/rcr_regs.sv ----
// Regulator configuration register bank with its decoded controls.
// Summary of operation
// - Ramp code 0 instant, 1-10 mV/us, above saturates.
// - Function bit 0 enables spread spectrum.
// - Bit 1 picks 10 kHz or 2 kHz triangle.
// - Bits 3..2 pick power-good delay, reset 01.
// - Power-good reset released after delay from monitor.
// - Undervoltage input forces all regulators off.
// - Bit 4 bypasses the undervoltage lockout.
// - First linear code maps 1.0 V to 3.5 V.
// - Second linear code maps the same way.
// - All registers readable and writable by host.
`timescale 1ns/1ns
module rcr_regs
    import rcr_pkg::*;
#(
    parameter int PG_CYC0 = RCR_PG_CYC0,
    parameter int PG_CYC1 = RCR_PG_CYC1,
    parameter int PG_CYC2 = RCR_PG_CYC2,
    parameter int PG_CYC3 = RCR_PG_CYC3,
    parameter int SS_HALF_FAST = RCR_SS_HALF_FAST,
    parameter int SS_HALF_SLOW = RCR_SS_HALF_SLOW
) (
    // Clock and reset.
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    // Register port from the serial engine.
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    // Analogue monitors.
    input wire logic I_BUCK1_GOOD,
    input wire logic I_BUCK2_GOOD,
    input wire logic I_INPUT_UNDERVOLTAGE_LOCKOUT,
    // Factory trim.
    input wire logic I_TRIM_LOCKOUT_MONITOR_BYPASS,
    input wire logic [4:0] I_TRIM_LINEAR_REG1_VOLTAGE_CODE,
    input wire logic [4:0] I_TRIM_LINEAR_REG2_VOLTAGE_CODE,
    // Regulator controls.
    output logic [3:0] O_SECOND_BUCK_RAMP_RATE,
    output logic O_SPREAD_ACTIVE,
    output logic O_SPREAD_UP,
    output logic O_POWER_GOOD_RESET_N,
    output logic O_REGULATORS_DISABLE,
    output logic [5:0] O_LINEAR_REG1_DECIVOLT,
    output logic [5:0] O_LINEAR_REG2_DECIVOLT
);
    function automatic logic [5:0] ldo_decode(input logic [4:0] code);
        ldo_decode = (code >= RCR_LDO_MAX) ? RCR_LDO_BASE + 6'(RCR_LDO_MAX) : RCR_LDO_BASE + 6'(code);
    endfunction : ldo_decode

    function automatic logic [7:0] merge(input logic [7:0] val, input logic [7:0] rst, input logic [7:0] msk);
        merge = (val & msk) | (rst & ~msk);
    endfunction : merge

    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == RCR_OFS_RAMP) || (addr == RCR_OFS_FUNC)
            || (addr == RCR_OFS_LDO1) || (addr == RCR_OFS_LDO2);
    endfunction : reg_hit

    rcr_req_t req;
    assign req = '{wr: I_REG_WR, rd: I_REG_RD, addr: I_REG_ADDR, wdata: I_REG_WDATA};

    logic [7:0] ramp_ff, nxt_ramp;
    logic [7:0] func_ff, nxt_func;
    logic [7:0] ldo1_ff, nxt_ldo1;
    logic [7:0] ldo2_ff, nxt_ldo2;
    logic trim_ff, nxt_trim;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic [3:0] rate_ff, nxt_rate;
    logic dis_ff, nxt_dis;
    logic [5:0] dv1_ff, nxt_dv1;
    logic [5:0] dv2_ff, nxt_dv2;

    // Register writes; trim load on the first edge after reset wins over a host write.
    always_comb begin
        nxt_ramp = ramp_ff;
        nxt_func = func_ff;
        nxt_ldo1 = ldo1_ff;
        nxt_ldo2 = ldo2_ff;
        nxt_trim = 1'b0;
        if (req.wr) begin
            unique case (req.addr)
                RCR_OFS_RAMP: nxt_ramp = merge(req.wdata, RCR_RST_RAMP, RCR_MSK_RAMP);
                RCR_OFS_FUNC: nxt_func = merge(req.wdata, RCR_RST_FUNC, RCR_MSK_FUNC);
                RCR_OFS_LDO1: nxt_ldo1 = merge(req.wdata, RCR_RST_LDO, RCR_MSK_LDO);
                RCR_OFS_LDO2: nxt_ldo2 = merge(req.wdata, RCR_RST_LDO, RCR_MSK_LDO);
                default: ;
            endcase
        end
        if (trim_ff) begin
            nxt_func[RCR_BIT_BYP] = I_TRIM_LOCKOUT_MONITOR_BYPASS;
            nxt_ldo1 = {3'h0, I_TRIM_LINEAR_REG1_VOLTAGE_CODE};
            nxt_ldo2 = {3'h0, I_TRIM_LINEAR_REG2_VOLTAGE_CODE};
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ramp_ff <= RCR_RST_RAMP;
            func_ff <= RCR_RST_FUNC;
            ldo1_ff <= RCR_RST_LDO;
            ldo2_ff <= RCR_RST_LDO;
            trim_ff <= 1'b1;
        end else begin
            ramp_ff <= nxt_ramp;
            func_ff <= nxt_func;
            ldo1_ff <= nxt_ldo1;
            ldo2_ff <= nxt_ldo2;
            trim_ff <= nxt_trim;
        end
    end

    // Read port; unmapped addresses answer zero.
    always_comb begin
        nxt_rvalid = req.rd;
        nxt_rdata = rdata_ff;
        if (req.rd) begin
            unique case (req.addr)
                RCR_OFS_RAMP: nxt_rdata = ramp_ff;
                RCR_OFS_FUNC: nxt_rdata = func_ff;
                RCR_OFS_LDO1: nxt_rdata = ldo1_ff;
                RCR_OFS_LDO2: nxt_rdata = ldo2_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Decoded controls toward the analogue side.
    always_comb begin
        nxt_rate = (ramp_ff[3:0] > RCR_RAMP_MAX) ? RCR_RAMP_MAX : ramp_ff[3:0];
        // Lockout is re-evaluated every cycle; no latching, so the disable clears on the next clock edge.
        nxt_dis = I_INPUT_UNDERVOLTAGE_LOCKOUT && !func_ff[RCR_BIT_BYP];
        nxt_dv1 = ldo_decode(ldo1_ff[4:0]);
        nxt_dv2 = ldo_decode(ldo2_ff[4:0]);
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            rate_ff <= RCR_RST_RAMP[3:0];
            dis_ff <= 1'b1;
            dv1_ff <= RCR_LDO_BASE;
            dv2_ff <= RCR_LDO_BASE;
        end else begin
            rate_ff <= nxt_rate;
            dis_ff <= nxt_dis;
            dv1_ff <= nxt_dv1;
            dv2_ff <= nxt_dv2;
        end
    end

    rcr_spread #(
        .HALF_FAST(SS_HALF_FAST),
        .HALF_SLOW(SS_HALF_SLOW)
    ) u_spread (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_enable(func_ff[RCR_BIT_SSEN]),
        .i_slow(func_ff[RCR_BIT_SLOW]),
        .o_active(O_SPREAD_ACTIVE),
        .o_up(O_SPREAD_UP)
    );

    rcr_pg_delay #(
        .CYC0(PG_CYC0),
        .CYC1(PG_CYC1),
        .CYC2(PG_CYC2),
        .CYC3(PG_CYC3)
    ) u_pg_delay (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_ok(I_BUCK1_GOOD && I_BUCK2_GOOD),
        .i_sel(func_ff[RCR_BIT_DLY +: 2]),
        .o_reset_n(O_POWER_GOOD_RESET_N)
    );

    assign O_REG_RDATA = rdata_ff;
    assign O_REG_RVALID = rvalid_ff;
    assign O_SECOND_BUCK_RAMP_RATE = rate_ff;
    assign O_REGULATORS_DISABLE = dis_ff;
    assign O_LINEAR_REG1_DECIVOLT = dv1_ff;
    assign O_LINEAR_REG2_DECIVOLT = dv2_ff;

    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    property p_ramp_map;
        ramp_ff[3:0] > RCR_RAMP_MAX |=> rate_ff == RCR_RAMP_MAX || $changed(ramp_ff);
    endproperty
    a_ramp_map: assert property (p_ramp_map) else $error("ramp code not saturated");

    property p_ss_off;
        !func_ff[RCR_BIT_SSEN] |=> !O_SPREAD_ACTIVE;
    endproperty
    a_ss_off: assert property (p_ss_off) else $error("spread active while off");

    property p_lockout;
        I_INPUT_UNDERVOLTAGE_LOCKOUT && !func_ff[RCR_BIT_BYP] |=> dis_ff;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout did not disable");

    property p_bypass;
        func_ff[RCR_BIT_BYP] |=> !dis_ff;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass ignored");

    property p_ldo1;
        ##1 dv1_ff == (($past(ldo1_ff[4:0]) >= RCR_LDO_MAX) ? 6'h23 : 6'h0A + 6'($past(ldo1_ff[4:0])));
    endproperty
    a_ldo1: assert property (p_ldo1) else $error("first linear map wrong");

    property p_ldo2;
        ##1 dv2_ff == (($past(ldo2_ff[4:0]) >= RCR_LDO_MAX) ? 6'h23 : 6'h0A + 6'($past(ldo2_ff[4:0])));
    endproperty
    a_ldo2: assert property (p_ldo2) else $error("second linear map wrong");

    sequence s_func_write;
        req.wr && req.addr == RCR_OFS_FUNC && !trim_ff;
    endsequence
    property p_write_read;
        s_func_write ##1 (req.rd && req.addr == RCR_OFS_FUNC && !req.wr && !trim_ff)
            |=> rvalid_ff && rdata_ff == {3'h0, $past(req.wdata[4:0], 2)};
    endproperty
    a_write_read: assert property (p_write_read) else $error("readback mismatch");

    property p_reserved;
        rvalid_ff |-> (($past(req.addr) == RCR_OFS_RAMP) ? (rdata_ff[7:4] == RCR_RST_RAMP[7:4])
            : (rdata_ff[7:5] == 3'h0));
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits wrong");

    property p_trim;
        trim_ff |=> ldo1_ff == {3'h0, $past(I_TRIM_LINEAR_REG1_VOLTAGE_CODE)}
            && func_ff[RCR_BIT_BYP] == $past(I_TRIM_LOCKOUT_MONITOR_BYPASS);
    endproperty
    a_trim: assert property (p_trim) else $error("trim not loaded");

    property p_trim2;
        trim_ff |=> ldo2_ff == {3'h0, $past(I_TRIM_LINEAR_REG2_VOLTAGE_CODE)};
    endproperty
    a_trim2: assert property (p_trim2) else $error("second trim not loaded");

    property p_rvalid;
        req.rd |=> rvalid_ff;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");

    property p_rvalid_pulse;
        !req.rd |=> !rvalid_ff;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

    property p_rdata_hold;
        !req.rd |=> $stable(rdata_ff);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

    property p_unmapped_rd;
        req.rd && !reg_hit(req.addr) |=> rdata_ff == 8'h00;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    // Writes to unmapped offsets must leave every register alone.
    property p_unmapped_wr;
        req.wr && !reg_hit(req.addr) && !trim_ff
            |=> $stable(ramp_ff) && $stable(func_ff) && $stable(ldo1_ff) && $stable(ldo2_ff);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed a register");

    property p_ramp_wr;
        req.wr && req.addr == RCR_OFS_RAMP |=> ramp_ff == {RCR_RST_RAMP[7:4], $past(req.wdata[3:0])};
    endproperty
    a_ramp_wr: assert property (p_ramp_wr) else $error("ramp write wrong");

    property p_func_wr;
        req.wr && req.addr == RCR_OFS_FUNC && !trim_ff |=> func_ff == {3'h0, $past(req.wdata[4:0])};
    endproperty
    a_func_wr: assert property (p_func_wr) else $error("function write wrong");

    property p_ramp_pass;
        ramp_ff[3:0] <= RCR_RAMP_MAX |=> rate_ff == $past(ramp_ff[3:0]);
    endproperty
    a_ramp_pass: assert property (p_ramp_pass) else $error("ramp code not passed");

    property p_unlock;
        !I_INPUT_UNDERVOLTAGE_LOCKOUT |=> !dis_ff;
    endproperty
    a_unlock: assert property (p_unlock) else $error("disable held without lockout");

    property p_ss_on;
        func_ff[RCR_BIT_SSEN] |=> O_SPREAD_ACTIVE;
    endproperty
    a_ss_on: assert property (p_ss_on) else $error("spread not active while on");

    property p_pg_low;
        !(I_BUCK1_GOOD && I_BUCK2_GOOD) |=> !O_POWER_GOOD_RESET_N;
    endproperty
    a_pg_low: assert property (p_pg_low) else $error("power good reset not asserted");
endmodule : rcr_regs

// ---- tb/rcr_host_model.sv ----
// Host-side model that issues register accesses on the parallel strobe port.
`timescale 1ns/1ns
module rcr_host_model (
    // Clock.
    input wire logic i_clk,
    // Register port.
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hFF;
        o_wdata = 8'hFF;
    end

    // Released address and data lines show the inverse, so a stale value never passes for a live one.
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr = wr;
        o_rd = ~wr;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : access

    // Back-to-back write then read of one offset.
    task automatic write_read(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_wr = 1'b1;
        o_rd = 1'b0;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b1;
        o_wdata = ~d;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
    endtask : write_read
endmodule : rcr_host_model

// ---- tb/tb.sv ----
// Self-checking bench for the regulator configuration register bank.
`timescale 1ns/1ns
module tb;
    import rcr_pkg::*;
    localparam int PG [4] = '{4, 8, 12, 16};
    localparam int SS_F = 5;
    localparam int SS_S = 9;
    logic clk = 1'b0;
    logic rst, wr_s, rd_s, b1, b2, uv;
    logic [7:0] addr, wdata, rdata;
    logic rvalid, ss_act, ss_up, pg_n, dis;
    logic [3:0] ramp;
    logic [5:0] v1, v2;
    logic [7:0] exp_q [$];
    logic [7:0] rnd = 8'h1D;
    int n_tests = 0;
    int n_fail = 0;
    int k;
    logic trim_byp = 1'b0;
    logic [4:0] trim1 = 5'h07;
    logic [4:0] trim2 = 5'h1C;

    always #4 clk = ~clk;

    rcr_host_model host_u (.i_clk(clk), .o_wr(wr_s), .o_rd(rd_s), .o_addr(addr), .o_wdata(wdata));

    rcr_regs #(.PG_CYC0(PG[0]), .PG_CYC1(PG[1]), .PG_CYC2(PG[2]), .PG_CYC3(PG[3]),
        .SS_HALF_FAST(SS_F), .SS_HALF_SLOW(SS_S)) dut_u (
        .I_CORE_CLK(clk), .I_RST(rst), .I_REG_WR(wr_s), .I_REG_RD(rd_s), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_BUCK1_GOOD(b1),
        .I_BUCK2_GOOD(b2), .I_INPUT_UNDERVOLTAGE_LOCKOUT(uv), .I_TRIM_LOCKOUT_MONITOR_BYPASS(trim_byp),
        .I_TRIM_LINEAR_REG1_VOLTAGE_CODE(trim1), .I_TRIM_LINEAR_REG2_VOLTAGE_CODE(trim2),
        .O_SECOND_BUCK_RAMP_RATE(ramp), .O_SPREAD_ACTIVE(ss_act), .O_SPREAD_UP(ss_up),
        .O_POWER_GOOD_RESET_N(pg_n), .O_REGULATORS_DISABLE(dis), .O_LINEAR_REG1_DECIVOLT(v1),
        .O_LINEAR_REG2_DECIVOLT(v2));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Counts: tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
    endtask : wr

    // The expectation is queued before the strobe so the watcher always finds it.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask : rd

    // The first interval after a rate change may be partial, so the second one is measured.
    task automatic half_period(output int n);
        logic last;
        int t0;
        t0 = -1;
        n = 0;
        last = ss_up;
        for (int i = 0; i < 40 && n == 0; i++) begin
            cyc(1);
            if (ss_up !== last && t0 >= 0) begin
                n = i - t0;
            end else if (ss_up !== last) begin
                t0 = i;
            end
            last = ss_up;
        end
    endtask : half_period

    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("ERROR t=%0t unexpected read data", $time);
            end else begin
                check(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        #300000;
        n_fail++;
        $display("ERROR t=%0t run limit reached", $time);
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        b1 = 1'b1;
        b2 = 1'b1;
        uv = 1'b0;
        cyc(10);
        rst = 1'b0;
        cyc(3);
        rd(RCR_OFS_RAMP, RCR_RST_RAMP);
        rd(RCR_OFS_FUNC, 8'h06);
        rd(RCR_OFS_LDO1, 8'h07);
        rd(RCR_OFS_LDO2, 8'h1C);
        wr(8'h3B, 8'h5A);
        rd(8'h3B, 8'h00);
        check(ramp, 4'h8);
        check(v1, 6'h11);
        check(v2, 6'h23);
        $display("Test reset values done");
        for (int c = 0; c < 16; c++) begin
            rnd = lfsr(rnd);
            wr(RCR_OFS_RAMP, {rnd[7:4], 4'(c)});
            cyc(1);
            check(ramp, (c > 10) ? 4'hA : 4'(c));
            rd(RCR_OFS_RAMP, {4'h2, 4'(c)});
        end
        $display("Test ramp codes done");
        for (int c = 0; c < 32; c++) begin
            rnd = lfsr(rnd);
            wr(RCR_OFS_LDO1, {rnd[7:5], 5'(c)});
            wr(RCR_OFS_LDO2, {rnd[4:2], 5'(31 - c)});
            cyc(1);
            check(v1, 6'h0A + ((c > 25) ? 6'h19 : 6'(c)));
            check(v2, 6'h0A + ((31 - c > 25) ? 6'h19 : 6'(31 - c)));
            rd(RCR_OFS_LDO1, {3'h0, 5'(c)});
            rd(RCR_OFS_LDO2, {3'h0, 5'(31 - c)});
        end
        $display("Test linear codes done");
        wr(RCR_OFS_FUNC, 8'hE1);
        cyc(1);
        check(ss_act, 1'b1);
        half_period(k);
        check(k, SS_F);
        wr(RCR_OFS_FUNC, 8'hE3);
        half_period(k);
        check(k, SS_S);
        rd(RCR_OFS_FUNC, 8'h03);
        wr(RCR_OFS_FUNC, 8'h00);
        cyc(1);
        check({ss_act, ss_up}, 2'b01);
        $display("Test spread done");
        uv = 1'b1;
        cyc(2);
        check(dis, 1'b1);
        uv = 1'b0;
        cyc(2);
        check(dis, 1'b0);
        wr(RCR_OFS_FUNC, 8'h10);
        uv = 1'b1;
        cyc(2);
        check(dis, 1'b0);
        uv = 1'b0;
        exp_q.push_back(8'h14);
        host_u.write_read(RCR_OFS_FUNC, 8'hF4);
        $display("Test lockout done");
        for (int s = 0; s < 4; s++) begin
            wr(RCR_OFS_FUNC, 8'(s << 2));
            b1 = s[0];
            b2 = ~s[0];
            cyc(2);
            check(pg_n, 1'b0);
            b1 = 1'b1;
            b2 = 1'b1;
            k = 0;
            while (pg_n !== 1'b1 && k < 40) begin
                cyc(1);
                k++;
            end
            check(k, PG[s] + 1);
        end
        $display("Test power good done");
        rst = 1'b1;
        trim_byp = 1'b1;
        trim1 = 5'h19;
        trim2 = 5'h03;
        uv = 1'b1;
        cyc(2);
        check({pg_n, dis, rvalid}, 3'b010);
        rst = 1'b0;
        cyc(1);
        check(dis, 1'b1);
        cyc(1);
        check(dis, 1'b0);
        uv = 1'b0;
        rd(RCR_OFS_FUNC, 8'h16);
        rd(RCR_OFS_LDO1, 8'h19);
        rd(RCR_OFS_LDO2, 8'h03);
        check(v1, 6'h23);
        $display("Test second reset done");
        cyc(2);
        check(32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule : tb
